// >>> verilog/scg_pkg.sv
// Purpose: shared constants and types for the self gain stage
// Assumes: one clock, 24-bit two's complement coefficients
// Notes: gain coefficients are signed with 22 fraction bits
package scg_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int DATA_W = 24;
  localparam int WIDE_W = 50;
  localparam int GAIN_FRAC = 22;
  localparam int SER_BITS = 24;
  localparam int RATE_W = 20;
  localparam logic [5:0] SER_CNT_FULL = 6'h18;
  localparam logic [23:0] GAIN_RESET = 24'h000000;
  localparam logic signed [49:0] ROUND_HALF = 50'sh0000000200000;

  // ----------------------------------------------------------------
  // rate tables in milli samples per second, index is rate code, low two bits of it for the continuous tables
  // ----------------------------------------------------------------
  localparam logic [7:0][19:0] SINGLE_LF0 = {
    20'h1D4C0, 20'h0EA60, 20'h07530, 20'h03A98,
    20'h02710, 20'h01388, 20'h009C4, 20'h003E8};
  localparam logic [7:0][19:0] SINGLE_LF1 = {
    20'h186A0, 20'h0C350, 20'h061A8, 20'h030D4,
    20'h0208A, 20'h0104A, 20'h00820, 20'h00341};
  localparam logic [3:0][19:0] CONT_LF0 = {
    20'h75300, 20'h3A980, 20'h1D4C0, 20'h0EA60};
  localparam logic [3:0][19:0] CONT_LF1 = {
    20'h61A80, 20'h30D40, 20'h186A0, 20'h0C350};

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [23:0] self_offset;
    logic signed [23:0] sys_offset;
    logic signed [23:0] sys_gain;
  } scg_coef_t;

  typedef struct packed {
    logic [19:0] single_msps;
    logic [19:0] cont_msps;
    logic cont_ok;
  } scg_rate_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_SHIFT = 2'b01,
    SER_DONE = 2'b11
  } scg_ser_state_t;

endpackage

// >>> verilog/scg_rate_sel.sv
// Purpose: decode rate code and line frequency into output rates
// Assumes: select inputs are quasi static, same clock domain
// Notes: rates are given in milli samples per second
`timescale 1ns/1ps
module scg_rate_sel (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] rate_code,
  input wire logic line_freq_sel,
  output scg_pkg::scg_rate_t rate_q
);
  import scg_pkg::*;

  scg_rate_t rate_d;

  // ----------------------------------------------------------------
  // table lookup
  // ----------------------------------------------------------------
  always_comb begin
    rate_d = '0;
    if (!line_freq_sel) begin
      rate_d.single_msps = SINGLE_LF0[rate_code];
      if (rate_code[2]) begin
        rate_d.cont_msps = CONT_LF0[rate_code[1:0]];
        rate_d.cont_ok = 1'b1;
      end
    end else begin
      rate_d.single_msps = SINGLE_LF1[rate_code];
      if (rate_code[2]) begin
        rate_d.cont_msps = CONT_LF1[rate_code[1:0]];
        rate_d.cont_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= '0;
    end else begin
      rate_q <= rate_d;
    end
  end

endmodule

// >>> verilog/scg_gain_stage.sv
// Purpose: self gain register, serial access and correction chain
// Assumes: serial pins asynchronous to mclk, sclk well below mclk/4
// Notes: gain 24'h400000 is unity, full scale approaches two
`timescale 1ns/1ps
module scg_gain_stage (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ser_cs_n,
  input wire logic ser_sclk,
  input wire logic ser_din,
  input wire logic ser_rd,
  output logic ser_dout,
  output logic ser_dout_oe,
  input wire logic cal_busy,
  input wire logic cal_done,
  input wire logic [23:0] cal_gain,
  input wire logic bypass_self_gain,
  input wire logic bypass_self_offset,
  input wire logic bypass_system_offset,
  input wire logic bypass_system_gain,
  input scg_pkg::scg_coef_t coef,
  input wire logic raw_valid,
  input wire logic [23:0] raw_result,
  input wire logic [2:0] rate_code,
  input wire logic line_freq_sel,
  output logic [23:0] self_cal_gain_value,
  output logic write_dropped,
  output logic result_valid,
  output logic [23:0] result,
  output scg_pkg::scg_rate_t rate
);
  import scg_pkg::*;

  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic signed [23:0] sat24(
    input logic signed [49:0] v
  );
    if (v[49:23] == {27{v[49]}}) begin
      return v[23:0];
    end
    return v[49] ? 24'sh800000 : 24'sh7FFFFF;
  endfunction

  function automatic logic signed [23:0] sub_sat(
    input logic signed [23:0] a,
    input logic signed [23:0] b
  );
    logic signed [49:0] d;
    d = WIDE_W'(a) - WIDE_W'(b);
    return sat24(d);
  endfunction

  function automatic logic signed [23:0] mul_gain(
    input logic signed [23:0] x,
    input logic signed [23:0] g
  );
    logic signed [49:0] p;
    p = WIDE_W'(x) * WIDE_W'(g);
    p = p + ROUND_HALF;
    p = p >>> GAIN_FRAC;
    return sat24(p);
  endfunction

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SER_BITS != DATA_W) begin : g_ser_w
    $error("serial frame length must equal gain width");
  end
  if (SER_CNT_FULL != 6'(SER_BITS)) begin : g_cnt_w
    $error("bit counter ceiling must equal frame length");
  end
  if (WIDE_W < 2 * DATA_W + 1) begin : g_wide_w
    $error("product width too narrow for signed product");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic cs_prev_q;
  logic sclk_prev_q;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic rd_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 4'h8;
      pin_s2_q <= 4'h8;
    end else begin
      pin_s1_q <= {ser_cs_n, ser_sclk, ser_din, ser_rd};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign cs_n_s = pin_s2_q[3];
  assign sclk_s = pin_s2_q[2];
  assign din_s = pin_s2_q[1];
  assign rd_s = pin_s2_q[0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
    end
  end

  logic frame_start;
  logic sclk_rise;
  logic sclk_fall;
  assign frame_start = cs_prev_q && !cs_n_s;
  assign sclk_rise = !sclk_prev_q && sclk_s;
  assign sclk_fall = sclk_prev_q && !sclk_s;

  // ----------------------------------------------------------------
  // serial frame control
  // ----------------------------------------------------------------
  scg_ser_state_t state_q;
  logic [23:0] shift_q;
  logic [5:0] cnt_q;
  logic rd_q;
  logic [23:0] gain_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SER_IDLE;
    end else begin
      case (state_q)
        SER_IDLE: begin
          if (frame_start) begin
            state_q <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          if (cs_n_s) begin
            state_q <= SER_DONE;
          end
        end
        SER_DONE: begin
          state_q <= SER_IDLE;
        end
        default: begin
          state_q <= SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= '0;
      cnt_q <= '0;
      rd_q <= 1'b0;
    end else if (state_q == SER_IDLE && frame_start) begin
      shift_q <= gain_q;
      cnt_q <= '0;
      rd_q <= rd_s;
    end else if (state_q == SER_SHIFT && !cs_n_s && sclk_rise) begin
      shift_q <= {shift_q[22:0], din_s};
      if (cnt_q != SER_CNT_FULL) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_dout <= 1'b0;
      ser_dout_oe <= 1'b0;
    end else if (state_q == SER_IDLE && frame_start) begin
      ser_dout <= gain_q[SER_BITS-1];
      ser_dout_oe <= rd_s;
    end else if (state_q == SER_SHIFT && !cs_n_s) begin
      if (sclk_fall) begin
        ser_dout <= shift_q[SER_BITS-1];
      end
    end else begin
      ser_dout_oe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // gain register
  // ----------------------------------------------------------------
  logic wr_req;
  logic wr_ok;
  logic busy_seen_q;
  assign wr_req = state_q == SER_DONE && !rd_q && cnt_q == SER_CNT_FULL;
  assign wr_ok = wr_req && !cal_busy && !busy_seen_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_seen_q <= 1'b0;
    end else if (state_q == SER_IDLE && frame_start) begin
      busy_seen_q <= cal_busy;
    end else if (state_q == SER_SHIFT && cal_busy) begin
      busy_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gain_q <= GAIN_RESET;
    end else if (cal_done) begin
      gain_q <= cal_gain;
    end else if (wr_ok) begin
      gain_q <= shift_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      write_dropped <= 1'b0;
      self_cal_gain_value <= GAIN_RESET;
    end else begin
      write_dropped <= wr_req && (cal_busy || cal_done || busy_seen_q);
      self_cal_gain_value <= gain_q;
    end
  end

  // ----------------------------------------------------------------
  // correction chain
  // ----------------------------------------------------------------
  logic signed [23:0] s1_d;
  logic signed [23:0] s2_d;
  logic signed [23:0] s1_q;
  logic v1_q;

  always_comb begin
    s1_d = bypass_self_offset ? $signed(raw_result)
         : sub_sat($signed(raw_result), coef.self_offset);
    if (!bypass_self_gain) begin
      s1_d = mul_gain(s1_d, $signed(gain_q));
    end
  end

  always_comb begin
    s2_d = bypass_system_offset ? s1_q : sub_sat(s1_q, coef.sys_offset);
    if (!bypass_system_gain) begin
      s2_d = mul_gain(s2_d, coef.sys_gain);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      v1_q <= 1'b0;
      result <= '0;
      result_valid <= 1'b0;
    end else begin
      v1_q <= raw_valid;
      result_valid <= v1_q;
      if (raw_valid) begin
        s1_q <= s1_d;
      end
      if (v1_q) begin
        result <= s2_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // rate selection
  // ----------------------------------------------------------------
  scg_rate_sel u_rate (
    .mclk(mclk),
    .rst_n(rst_n),
    .rate_code(rate_code),
    .line_freq_sel(line_freq_sel),
    .rate_q(rate)
  );

endmodule

// >>> verif/scg_gain_stage_asserts.sv
// Purpose: port checks for the self gain stage
// Assumes: one clock, async active low reset
// Notes: bound into every scg_gain_stage
`timescale 1ns/1ps
module scg_gain_stage_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ser_cs_n,
  input wire logic ser_dout_oe,
  input wire logic cal_busy,
  input wire logic cal_done,
  input wire logic [23:0] cal_gain,
  input wire logic bypass_self_gain,
  input wire logic bypass_self_offset,
  input wire logic bypass_system_offset,
  input wire logic bypass_system_gain,
  input wire logic raw_valid,
  input wire logic [23:0] raw_result,
  input wire logic [2:0] rate_code,
  input wire logic line_freq_sel,
  input wire logic [23:0] self_cal_gain_value,
  input wire logic result_valid,
  input wire logic [23:0] result,
  input scg_pkg::scg_rate_t rate
);
  import scg_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  a_result_lat: assert property (raw_valid |-> ##2 result_valid)
    else $error("no result two cycles after raw input");
  a_cal_load: assert property (cal_done |-> ##2
    self_cal_gain_value == $past(cal_gain, 2))
    else $error("calibration gain not stored");
  a_busy_hold: assert property ($past(cal_busy, 2)
    && !$past(cal_done, 2) |-> $stable(self_cal_gain_value))
    else $error("gain changed during calibration");
  a_oe_idle: assert property (ser_cs_n [*6] |=> !ser_dout_oe)
    else $error("serial output driven outside a frame");
  a_rate_lf0: assert property ($past(rst_n) && !$past(line_freq_sel)
    && $past(rate_code) == 3'h0 |-> rate.single_msps == 20'h003E8)
    else $error("slowest 60 hz rate wrong");
  a_rate_lf1: assert property ($past(rst_n) && $past(line_freq_sel)
    && $past(rate_code) == 3'h7 |-> rate.cont_msps == 20'h61A80)
    else $error("fastest 50 hz rate wrong");
  a_cont_flag: assert property ($past(rst_n)
    |-> rate.cont_ok == $past(rate_code[2]))
    else $error("continuous flag wrong");
  a_bypass_pass: assert property (raw_valid && bypass_self_gain
    && bypass_self_offset && bypass_system_offset && bypass_system_gain
    |-> ##2 result == $past(raw_result, 2))
    else $error("full bypass altered the result");
  a_unity_gain: assert property (raw_valid && !bypass_self_gain
    && bypass_self_offset && bypass_system_offset && bypass_system_gain
    && self_cal_gain_value == 24'h400000
    |-> ##2 result == $past(raw_result, 2))
    else $error("unity gain altered the result");
endmodule

bind scg_gain_stage scg_gain_stage_asserts u_scg_gain_stage_asserts (
  .mclk, .rst_n, .ser_cs_n, .ser_dout_oe, .cal_busy, .cal_done,
  .cal_gain, .bypass_self_gain, .bypass_self_offset,
  .bypass_system_offset, .bypass_system_gain, .raw_valid, .raw_result,
  .rate_code, .line_freq_sel, .self_cal_gain_value, .result_valid,
  .result, .rate);

// >>> verif/scg_host_model.sv
// Purpose: host controller on the serial configuration pins
// Assumes: sclk half period of HALF mclk cycles
// Notes: din idles at the inverse of its last bit
`timescale 1ns/1ps
module scg_host_model #(
  parameter int HALF = 6
) (
  input wire logic mclk,
  output logic ser_cs_n,
  output logic ser_sclk,
  output logic ser_din,
  output logic ser_rd,
  input wire logic ser_dout
);
  initial begin
    ser_cs_n = 1'b1;
    ser_sclk = 1'b0;
    ser_din = 1'b0;
    ser_rd = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic xfer(input logic rd, input logic [23:0] wd,
                      input int nb, output logic [23:0] rv);
    rv = 24'h000000;
    ser_rd = rd;
    ser_cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      ser_din = wd[23-i];
      wait_n(HALF);
      rv = {rv[22:0], ser_dout};
      ser_sclk = 1'b1;
      wait_n(HALF);
      ser_sclk = 1'b0;
    end
    wait_n(HALF);
    ser_cs_n = 1'b1;
    ser_din = ~ser_din;
    wait_n(HALF);
  endtask
endmodule

// >>> verif/scg_gain_stage_test.sv
// Purpose: self-checking bench for the self gain stage
// Assumes: host model drives the serial pins
// Notes: data-test gain loads use the calibration path for speed
`timescale 1ns/1ps
module scg_gain_stage_test;
  import scg_pkg::*;
  typedef struct {
    logic [3:0] b;
    logic [23:0] g, so, syo, syg, raw, exp;
  } scg_case_t;
  logic mclk, rst_n, ser_cs_n, ser_sclk, ser_din, ser_rd, ser_dout;
  logic cal_busy, cal_done, raw_valid, line_freq_sel, drop_seen;
  logic write_dropped, result_valid, ser_dout_oe, dout_line, oe_seen;
  logic [23:0] cal_gain, raw_result, self_cal_gain_value, result, rv;
  logic [3:0] byp;
  logic [2:0] rate_code;
  scg_coef_t coef;
  scg_rate_t rate;
  int n_fail = 0, n_checks = 0, cyc = 0;

  scg_gain_stage u_scg_gain_stage (.mclk(mclk), .rst_n(rst_n),
    .ser_cs_n(ser_cs_n), .ser_sclk(ser_sclk), .ser_din(ser_din),
    .ser_rd(ser_rd), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe),
    .cal_busy(cal_busy), .cal_done(cal_done), .cal_gain(cal_gain),
    .bypass_self_gain(byp[3]), .bypass_self_offset(byp[2]),
    .bypass_system_offset(byp[1]), .bypass_system_gain(byp[0]),
    .coef(coef), .raw_valid(raw_valid), .raw_result(raw_result),
    .rate_code(rate_code), .line_freq_sel(line_freq_sel),
    .self_cal_gain_value(self_cal_gain_value),
    .write_dropped(write_dropped), .result_valid(result_valid),
    .result(result), .rate(rate));
  scg_host_model u_scg_host_model (.mclk(mclk), .ser_cs_n(ser_cs_n),
    .ser_sclk(ser_sclk), .ser_din(ser_din), .ser_rd(ser_rd),
    .ser_dout(dout_line));
  // released data line pulled high
  assign dout_line = ser_dout_oe ? ser_dout : 1'b1;

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (write_dropped === 1'b1) drop_seen = 1'b1;
    if (ser_dout_oe === 1'b1) oe_seen = 1'b1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_v(string nm, logic [23:0] e, logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_b(string nm, logic e, logic g);
    chk_v(nm, {23'h0, e}, {23'h0, g});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic load_cal(input logic [23:0] g);
    cal_gain = g;
    cal_done = 1'b1;
    wait_n(1);
    cal_done = 1'b0;
    wait_n(2);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_wr_rd;
    logic [23:0] v [2] = '{24'hA5C3F1, 24'h800001};
    foreach (v[i]) begin
      oe_seen = 1'b0;
      u_scg_host_model.xfer(1'b0, v[i], 24, rv);
      wait_n(10);
      chk_v("gain", v[i], self_cal_gain_value);
      chk_b("write oe", 1'b0, oe_seen);
      u_scg_host_model.xfer(1'b1, 24'h000000, 24, rv);
      chk_v("readback", v[i], rv);
      chk_b("read oe", 1'b1, oe_seen);
      chk_v("kept", v[i], self_cal_gain_value);
    end
    $display("test wr_rd ended");
  endtask
  task automatic t_busy;
    cal_busy = 1'b1;
    drop_seen = 1'b0;
    u_scg_host_model.xfer(1'b0, 24'h123456, 24, rv);
    wait_n(10);
    chk_v("busy gain", 24'h800001, self_cal_gain_value);
    chk_b("dropped", 1'b1, drop_seen);
    cal_busy = 1'b0;
    drop_seen = 1'b0;
    u_scg_host_model.xfer(1'b0, 24'h654321, 20, rv);
    wait_n(10);
    chk_v("short gain", 24'h800001, self_cal_gain_value);
    chk_b("short drop", 1'b0, drop_seen);
    load_cal(24'h3FFFFF);
    chk_v("cal gain", 24'h3FFFFF, self_cal_gain_value);
    u_scg_host_model.xfer(1'b1, 24'h000000, 24, rv);
    chk_v("cal read", 24'h3FFFFF, rv);
    $display("test busy_cal ended");
  endtask
  task automatic t_data;
    scg_case_t c [9] = '{
      '{4'hF, 24'h400000, 0, 0, 0, 24'h654321, 24'h654321},
      '{4'h7, 24'h400000, 0, 0, 0, 24'h123456, 24'h123456},
      '{4'h7, 24'h200000, 0, 0, 0, 24'h000100, 24'h000080},
      '{4'h7, 24'h200000, 0, 0, 0, 24'hFFFF00, 24'hFFFF80},
      '{4'h7, 24'hC00000, 0, 0, 0, 24'h000100, 24'hFFFF00},
      '{4'h7, 24'h7FFFFF, 0, 0, 0, 24'h001000, 24'h002000},
      '{4'h3, 24'h200000, 24'h40, 0, 0, 24'h000140, 24'h80},
      '{4'h5, 24'h200000, 0, 24'h10, 0, 24'h000100, 24'h70},
      '{4'h4, 24'h200000, 0, 24'h10, 24'h200000, 24'h100, 24'h38}};
    foreach (c[i]) begin
      load_cal(c[i].g);
      byp = c[i].b;
      coef = '{c[i].so, c[i].syo, c[i].syg};
      raw_result = c[i].raw;
      raw_valid = 1'b1;
      wait_n(1);
      raw_valid = 1'b0;
      wait_n(1);
      chk_b("valid", 1'b1, result_valid);
      chk_v("result", c[i].exp, result);
    end
    $display("test data ended");
  endtask
  task automatic t_rate;
    int s [2][8] = '{'{1000, 2500, 5000, 10000, 15000, 30000, 60000,
      120000}, '{833, 2080, 4170, 8330, 12500, 25000, 50000, 100000}};
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 8; k++) begin
        line_freq_sel = f[0];
        rate_code = k[2:0];
        wait_n(2);
        chk_v("single", 24'(s[f][k]), {4'h0, rate.single_msps});
        chk_v("cont", k > 3 ? 24'(4 * s[f][k]) : 24'h0, {4'h0, rate.cont_msps});
        chk_b("cont ok", k[2], rate.cont_ok);
      end
    end
    $display("test rate ended");
  endtask
  initial begin
    rst_n = 1'b0;
    {cal_busy, cal_done, raw_valid, line_freq_sel, drop_seen, oe_seen} = 6'h00;
    {cal_gain, raw_result} = 48'h0;
    byp = 4'hF;
    coef = '0;
    rate_code = 3'h0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    wait_n(2);
    chk_v("reset gain", 24'h000000, self_cal_gain_value);
    t_wr_rd();
    t_busy();
    t_data();
    t_rate();
    results();
  end
endmodule
